// ==== shared/lec1_defines.vh ====
`ifndef LEC1_DEFINES_VH
`define LEC1_DEFINES_VH
// register byte addresses (printed offset 0x311 is not a multiple of four)
`define LEC1_IDX_CTRL1 12'h311
`define LEC1_ADDR_CTRL1 14'h0C44
`define LEC1_IDX_CTRL2 12'h312
`define LEC1_ADDR_CTRL2 14'h0C48
`define LEC1_IDX_AGE 12'h313
`define LEC1_ADDR_AGE 14'h0C4C
`define LEC1_ADDR_STAT 14'h0C50
// control one fields
`define LEC1_B_LRN_DIS 7
`define LEC1_B_SELF_FLT 6
`define LEC1_B_FLUSH_ALL 5
`define LEC1_B_FLUSH_MST 4
`define LEC1_B_MC_SA_FWD 3
`define LEC1_B_AGE_EN 2
`define LEC1_B_FAST_AGE 1
`define LEC1_B_LINK_FLUSH 0
`define LEC1_CTRL1_RST 8'h0C
// control two: flush scope in bits 3:2, age count in bits 6:4
`define LEC1_SCOPE_LSB 2
`define LEC1_SCOPE_NONE 2'h0
`define LEC1_SCOPE_DYN 2'h1
`define LEC1_SCOPE_STAT 2'h2
`define LEC1_SCOPE_BOTH 2'h3
`define LEC1_AGECNT_LSB 4
`define LEC1_AGECNT_RST 3'h4
`define LEC1_CTRL2_RST 8'h40
`define LEC1_AGE_PER_RST 8'h4B
// table and timing
`define LEC1_ENTRIES 16
`define LEC1_TICK_NS 1000
`define LEC1_TICK_CYC (`LEC1_TICK_NS / 10)
`define LEC1_TICK_RLD 7'h63
`define LEC1_FAST_DIV 8'h08
`endif

// ==== verilog/lec1_ctrl.v ====
`timescale 1ns/1ps
`include "lec1_defines.vh"
// Overview of operation
// - bit 7 set stops unicast source learning
// - bit 6 drops frames sourced from station address
// - self-drop only where port filter enable set
// - bit 5 flushes in-scope entries of every instance, self clears
// - flush scope picks dynamic, static or both
// - bit 4 flushes matching spanning-tree instance entries
// - bit 3 forwards multicast-source frames, else drop
// - bit 2 enables aging; clear suspends aging
// - bit 1 selects fast aging
// - bit 0 flushes entries of link-down ports
// - scope codes: none, dynamic, static, both
// - age count loaded on update, period-timed
module lec1_ctrl (
  input wire CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [13:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire [47:0] STATION_ADDR,
  input wire [2:0] PORT_SELF_EN,
  input wire [2:0] LINK_UP,
  input wire [3:0] MST_SEL,
  input wire RX_VALID,
  input wire [1:0] RX_PORT,
  input wire [47:0] RX_SA,
  output reg RX_DROP,
  output reg RX_DROP_VALID,
  output reg [15:0] ENTRY_VALID,
  output reg [15:0] ENTRY_STATIC,
  output wire FLUSH_BUSY
);

  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [7:0] age_per_q;
  reg [31:0] rdata_q;
  reg [1:0] ent_port_q [0:15];
  reg [3:0] ent_mst_q [0:15];
  reg [2:0] ent_age_q [0:15];
  reg [3:0] sweep_q;
  reg sweep_busy_q;
  reg sweep_all_q;
  reg [2:0] link_q;
  reg [2:0] down_pend_q;
  reg [6:0] tick_cnt_q;
  reg [7:0] per_cnt_q;
  reg [3:0] age_idx_q;
  integer i;
  integer k;
  reg [31:0] rdata_d;
  // sweep states live in sweep_busy_q so FLUSH_BUSY stays a plain flop
  localparam SW_IDLE = 1'b0;
  localparam SW_RUN = 1'b1;

  wire wr = PSEL && PENABLE && PWRITE;
  wire wr_ctrl1 = wr && (PADDR == `LEC1_ADDR_CTRL1);
  wire wr_ctrl2 = wr && (PADDR == `LEC1_ADDR_CTRL2);
  wire wr_age = wr && (PADDR == `LEC1_ADDR_AGE);
  // read data captured in setup so PRDATA comes from a flop, not the mux
  wire rd_setup = PSEL && !PENABLE && !PWRITE;
  wire [1:0] scope = ctrl2_q[`LEC1_SCOPE_LSB+1:`LEC1_SCOPE_LSB];
  wire sweep_go = (ctrl1_q[`LEC1_B_FLUSH_ALL] || ctrl1_q[`LEC1_B_FLUSH_MST]) && !sweep_busy_q;
  wire tick = (tick_cnt_q == 7'h00);
  wire age_step;
  wire sweep_hit;
  wire sweep_last;
  wire learn_en;

  function mapped;
    input [13:0] a;
    begin
      mapped = (a == `LEC1_ADDR_CTRL1) || (a == `LEC1_ADDR_CTRL2) ||
               (a == `LEC1_ADDR_AGE) || (a == `LEC1_ADDR_STAT);
    end
  endfunction

  // scope decode: does this entry fall inside the flush scope
  function in_scope;
    input [1:0] sc;
    input is_static;
    begin
      case (sc)
        `LEC1_SCOPE_DYN: in_scope = !is_static;
        `LEC1_SCOPE_STAT: in_scope = is_static;
        `LEC1_SCOPE_BOTH: in_scope = 1'b1;
        default: in_scope = 1'b0;
      endcase
    end
  endfunction

  // there is no port three; indexing past the vector would give an unknown
  function port_bit;
    input [2:0] vec;
    input [1:0] port;
    begin
      if (port == 2'h3) begin
        port_bit = 1'b0;
      end else begin
        port_bit = vec[port];
      end
    end
  endfunction

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
  assign PRDATA = rdata_q;
  assign FLUSH_BUSY = sweep_busy_q;

  ////////////////////////////////////////////////////////////////////
  // registers; flush bits hold 1 while sweeping so no write clears them
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl1_q <= `LEC1_CTRL1_RST;
      ctrl2_q <= `LEC1_CTRL2_RST;
      age_per_q <= `LEC1_AGE_PER_RST;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_q[7:6] <= PWDATA[7:6];
        ctrl1_q[3:0] <= PWDATA[3:0];
        if (!sweep_busy_q) begin
          ctrl1_q[5:4] <= PWDATA[5:4];
        end
      end
      if (wr_ctrl2) begin
        ctrl2_q <= {1'b0, PWDATA[6:0]};
      end
      if (wr_age) begin
        age_per_q <= PWDATA[7:0];
      end
      if (sweep_last) begin
        ctrl1_q[`LEC1_B_FLUSH_ALL] <= 1'b0;
        ctrl1_q[`LEC1_B_FLUSH_MST] <= 1'b0;
      end
    end
  end

  always @* begin
    case (PADDR)
      `LEC1_ADDR_CTRL1: rdata_d = {24'h000000, ctrl1_q};
      `LEC1_ADDR_CTRL2: rdata_d = {24'h000000, ctrl2_q};
      `LEC1_ADDR_AGE: rdata_d = {24'h000000, age_per_q};
      `LEC1_ADDR_STAT: rdata_d = {16'h0000, ENTRY_VALID};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h00000000;
    end else if (rd_setup) begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // frame filtering, one cycle after the header strobe
  wire self_hit = ctrl1_q[`LEC1_B_SELF_FLT] && port_bit(PORT_SELF_EN, RX_PORT) &&
                  (RX_SA == STATION_ADDR);
  wire mc_hit = !ctrl1_q[`LEC1_B_MC_SA_FWD] && RX_SA[40];

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RX_DROP <= 1'b0;
      RX_DROP_VALID <= 1'b0;
    end else begin
      RX_DROP_VALID <= RX_VALID;
      RX_DROP <= RX_VALID && (self_hit || mc_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // aging: 1 us tick, period counter, fast mode reloads a fixed 8 instead of the period
  assign age_step = tick && (per_cnt_q == 8'h00) && ctrl1_q[`LEC1_B_AGE_EN];

  // free-running timebase; aging off only gates the step, not the tick
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_q <= 7'h00;
    end else if (tick) begin
      tick_cnt_q <= `LEC1_TICK_RLD;
    end else begin
      tick_cnt_q <= tick_cnt_q - 7'h01;
    end
  end

  // a change of aging mode takes effect at the next period reload only
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_cnt_q <= 8'h00;
    end else if (tick) begin
      if (per_cnt_q == 8'h00) begin
        per_cnt_q <= ctrl1_q[`LEC1_B_FAST_AGE] ? `LEC1_FAST_DIV : age_per_q;
      end else begin
        per_cnt_q <= per_cnt_q - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link-down detect: a falling level on a port arms one flush pulse
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      link_q <= 3'h7;
      down_pend_q <= 3'h0;
    end else begin
      link_q <= LINK_UP;
      if (ctrl1_q[`LEC1_B_LINK_FLUSH]) begin
        down_pend_q <= link_q & ~LINK_UP;
      end else begin
        down_pend_q <= 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sweep sequencer: one entry per cycle, sixteen cycles per flush
  assign sweep_last = sweep_busy_q && (sweep_q == 4'hF);
  assign sweep_hit = sweep_busy_q && in_scope(scope, ENTRY_STATIC[sweep_q]) &&
                     (sweep_all_q || (ent_mst_q[sweep_q] == MST_SEL));

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sweep_busy_q <= SW_IDLE;
      sweep_all_q <= 1'b0;
      sweep_q <= 4'h0;
    end else begin
      case (sweep_busy_q)
        SW_IDLE: begin
          if (sweep_go) begin
            sweep_busy_q <= SW_RUN;
            sweep_all_q <= ctrl1_q[`LEC1_B_FLUSH_ALL];
            sweep_q <= 4'h0;
          end
        end
        SW_RUN: begin
          sweep_q <= sweep_q + 4'h1;
          if (sweep_last) begin
            sweep_busy_q <= SW_IDLE;
          end
        end
        default: begin
          sweep_busy_q <= SW_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // learning into a round-robin slot; static entries are never replaced,
  // and nothing is learned mid-sweep so a flush cannot miss a fresh entry
  assign learn_en = RX_VALID && !RX_SA[40] && !ctrl1_q[`LEC1_B_LRN_DIS] && !sweep_busy_q &&
                    !ENTRY_STATIC[age_idx_q];

  // per-entry port, instance and age count; valid bits are kept below
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      age_idx_q <= 4'h0;
      for (i = 0; i < `LEC1_ENTRIES; i = i + 1) begin
        ent_port_q[i] <= 2'h0;
        ent_mst_q[i] <= 4'h0;
        ent_age_q[i] <= 3'h0;
      end
    end else begin
      for (i = 0; i < `LEC1_ENTRIES; i = i + 1) begin
        if (age_step && ENTRY_VALID[i] && !ENTRY_STATIC[i] && (ent_age_q[i] != 3'h0)) begin
          ent_age_q[i] <= ent_age_q[i] - 3'h1;
        end
      end
      if (learn_en) begin
        ent_port_q[age_idx_q] <= RX_PORT;
        ent_mst_q[age_idx_q] <= MST_SEL;
        ent_age_q[age_idx_q] <= ctrl2_q[`LEC1_AGECNT_LSB+2:`LEC1_AGECNT_LSB];
        age_idx_q <= age_idx_q + 4'h1;
      end
    end
  end

  // valid bits: sweep, link-down and age-out clear; learning comes last and wins
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ENTRY_VALID <= 16'h0000;
      ENTRY_STATIC <= 16'h0000;
    end else begin
      // no static load path in this block, so the static flags stay clear
      ENTRY_STATIC <= 16'h0000;
      if (sweep_hit) begin
        ENTRY_VALID[sweep_q] <= 1'b0;
      end
      for (k = 0; k < `LEC1_ENTRIES; k = k + 1) begin
        if (ENTRY_VALID[k] && !ENTRY_STATIC[k] && port_bit(down_pend_q, ent_port_q[k])) begin
          ENTRY_VALID[k] <= 1'b0;
        end
        if (age_step && ENTRY_VALID[k] && !ENTRY_STATIC[k] && (ent_age_q[k] == 3'h0)) begin
          ENTRY_VALID[k] <= 1'b0;
        end
      end
      if (learn_en) begin
        ENTRY_VALID[age_idx_q] <= 1'b1;
      end
    end
  end

endmodule // lec1_ctrl

// ==== testbench/lec1_ctrl_assertions.sv ====
`timescale 1ns/1ps
`include "lec1_defines.vh"
module lec1_ctrl_chk (
  input wire CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [13:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PSLVERR,
  input wire [47:0] STATION_ADDR,
  input wire [2:0] PORT_SELF_EN,
  input wire RX_VALID,
  input wire [1:0] RX_PORT,
  input wire [47:0] RX_SA,
  input wire RX_DROP,
  input wire RX_DROP_VALID,
  input wire FLUSH_BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_wr1;
    PSEL && PENABLE && PWRITE && PADDR == `LEC1_ADDR_CTRL1;
  endsequence
  sequence s_busy8;
    FLUSH_BUSY [*8];
  endsequence
  chk_drop_timing: assert property (RX_DROP_VALID == $past(RX_VALID))
    else $error("drop verdict timing wrong");
  chk_drop_qual: assert property (RX_DROP |-> RX_DROP_VALID)
    else $error("drop without verdict");
  chk_self_port: assert property (RX_VALID && RX_SA == STATION_ADDR && !RX_SA[40] &&
    !PORT_SELF_EN[RX_PORT] |=> !RX_DROP) else $error("self drop on disabled port");
  chk_flush_start: assert property (s_wr1 ##0 (PWDATA[5] && !FLUSH_BUSY) |=> ##1 FLUSH_BUSY)
    else $error("flush did not start");
  chk_mst_start: assert property (s_wr1 ##0 (PWDATA[4] && !FLUSH_BUSY) |=> ##1 FLUSH_BUSY)
    else $error("instance flush did not start");
  chk_flush_len: assert property ($rose(FLUSH_BUSY) |-> s_busy8 ##1 s_busy8 ##1 !FLUSH_BUSY)
    else $error("sweep length wrong");
  chk_busy_read: assert property (FLUSH_BUSY && PSEL && PENABLE && !PWRITE &&
    PADDR == `LEC1_ADDR_CTRL1 |-> |PRDATA[5:4]) else $error("flush bit read low while busy");
  chk_err_map: assert property (PSEL && PENABLE |-> PSLVERR == !(PADDR inside {`LEC1_ADDR_CTRL1,
    `LEC1_ADDR_CTRL2, `LEC1_ADDR_AGE, `LEC1_ADDR_STAT})) else $error("error response wrong");
endmodule // lec1_ctrl_chk
////////////////////////////////////////
bind lec1_ctrl lec1_ctrl_chk u_chk (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PSLVERR, .STATION_ADDR, .PORT_SELF_EN, .RX_VALID, .RX_PORT, .RX_SA, .RX_DROP, .RX_DROP_VALID, .FLUSH_BUSY);

// ==== testbench/tb_lookup_engine_control_one.sv ====
`timescale 1ns/1ps
`include "lec1_defines.vh"
module tb_lookup_engine_control_one;
  localparam [13:0] C1 = `LEC1_ADDR_CTRL1, C2 = `LEC1_ADDR_CTRL2, ST = `LEC1_ADDR_STAT;
  localparam [47:0] MC = 48'h0100_0000_0001;
  reg CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, RX_VALID = 0;
  reg [13:0] PADDR = 0;
  reg [31:0] PWDATA = 0, d, s;
  reg [47:0] STATION_ADDR = 48'h0200_1122_3344, RX_SA = 0;
  reg [2:0] PORT_SELF_EN = 3'h1, LINK_UP = 3'h7;
  reg [3:0] MST_SEL = 4'h3;
  reg [1:0] RX_PORT = 0;
  wire [31:0] PRDATA;
  wire [15:0] ENTRY_VALID, ENTRY_STATIC;
  wire PREADY, PSLVERR, RX_DROP, RX_DROP_VALID, FLUSH_BUSY;
  integer err_count = 0, comparisons = 0, i, j;
  always #5 CLK = ~CLK;
  lec1_ctrl dut (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .STATION_ADDR, .PORT_SELF_EN, .LINK_UP, .MST_SEL, .RX_VALID, .RX_PORT, .RX_SA, .RX_DROP,
    .RX_DROP_VALID, .ENTRY_VALID, .ENTRY_STATIC, .FLUSH_BUSY);
  ////////////////////////////////////////
  task chk(input string nm, input [31:0] e, input [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ap(input w, input [13:0] a, input [31:0] v);
    @(posedge CLK);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= v;
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    d = PRDATA;
    PSEL <= 0; PENABLE <= 0;
  endtask
  task rc(input [13:0] a, input [31:0] e, input string nm);
    ap(0, a, 0);
    chk(nm, e, d);
  endtask
  task frm(input [1:0] p, input [47:0] sa, input e);
    @(posedge CLK);
    RX_VALID <= 1; RX_PORT <= p; RX_SA <= sa;
    @(posedge CLK);
    RX_VALID <= 0;
    #1 chk("drop", e, RX_DROP);
  endtask
  // polls entries; long bound covers the slowest fast-aging expiry
  task pol(input [15:0] e, input integer n);
    j = 0;
    while (ENTRY_VALID !== e && j < n) begin @(posedge CLK); j++; end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin #600000; err_count++; end_sim; end
  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1;
    rc(C1, 32'h0C, "ctrl1");
    rc(C2, 32'h40, "ctrl2"); rc(14'h0C54, 0, "unmapped");
    ap(1, C1, 32'h4C); frm(0, STATION_ADDR, 1);
    frm(1, STATION_ADDR, 0);
    ap(1, C1, 32'h0C); frm(0, STATION_ADDR, 0);
    frm(2, MC, 0);
    ap(1, C1, 32'h04); frm(2, MC, 1);
    $display("filter test done");
    ap(1, C2, 32'h4C); ap(1, C1, 32'h2C); repeat (20) @(posedge CLK);
    ap(1, C1, 32'h8C); frm(1, 48'h10, 0); rc(ST, 0, "no learn");
    ap(1, C1, 32'h0C); frm(1, 48'h11, 0); ap(0, ST, 0); chk("learn", 1, $countones(d));
    for (i = 0; i < 4; i++) begin
      frm(1, 48'h20 + i, 0); ap(0, ST, 0); s = d;
      ap(1, C2, 32'h40 | (i << 2));
      ap(1, C1, i < 2 ? 32'h1C : 32'h2C);
      rc(C1, i < 2 ? 32'h1C : 32'h2C, "flush bit busy");
      j = 0;
      while (FLUSH_BUSY !== 1'b0 && j < 40) begin @(posedge CLK); j++; end
      rc(C1, 32'h0C, "self clear");
      rc(ST, i[0] ? 0 : s, "scope");
    end
    frm(1, 48'h28, 0); ap(0, ST, 0); s = d; MST_SEL <= 4'h5;
    ap(1, C2, 32'h44); ap(1, C1, 32'h1C); repeat (20) @(posedge CLK);
    rc(ST, s, "other instance kept"); MST_SEL <= 4'h3;
    $display("flush test done");
    frm(1, 48'h30, 0); ap(0, ST, 0); s = d;
    LINK_UP <= 3'h5; repeat (30) @(posedge CLK);
    rc(ST, s, "link kept");
    LINK_UP <= 3'h7; ap(1, C1, 32'h0D); LINK_UP <= 3'h5; pol(0, 40);
    rc(ST, 0, "link flush");
    LINK_UP <= 3'h7; ap(1, C1, 32'h0C); frm(1, 48'h40, 0); ap(0, ST, 0); s = d;
    ap(1, C1, 32'h08); repeat (5000) @(posedge CLK);
    rc(ST, s, "aging off");
    // up to 76 ticks of the old normal period may remain before the first fast reload
    ap(1, C1, 32'h0E); pol(0, 12000);
    rc(ST, 0, "fast aging");
    chk("static", 0, ENTRY_STATIC);
    $display("link and aging test done");
    end_sim;
  end
endmodule // tb_lookup_engine_control_one
